// file: rtl/fcsm_device.sv
// flash command decoding state machine, device end
// Behaviour
// - pin reconfig second cycle 0-3, else error
// - pin reconfig returns within its suspend context
// - host changes block only after buffer full
// - count-load address is buffered write start
// - buffered write invalid while error latched
// - clear status accepted while suspended
// - suspend enters only after suspend latency
// - host silent during suspend latency
// - lock or config write ends in status
// - lock setup in erase suspend returns there
// - D0 confirm after setup, else resume
// - 20 then D0 in suspend does not resume
// - bad sequence sets status bits four, five
// - word count is low five bits, minus one
//
// Our own choices: the register offsets and the APB slave port.
`default_nettype none
module fcsm_device
  import fcsm_pkg::*;
(
  fcsm_if.device bus,
  output logic [1:0] pin_cfg_out,
  output logic [ADDR_W-1:0] buf_start_out,
  output logic [COUNT_W-1:0] buf_count_out,
  output logic [1:0] suspend_ctx_out
);
  // ==========================================================
  // states
  typedef enum logic [3:0] {
    FCSM_READY = 4'b0000,
    FCSM_ERS_SETUP = 4'b0001,
    FCSM_ERS_BUSY = 4'b0010,
    FCSM_PRG_SETUP = 4'b0011,
    FCSM_PRG_BUSY = 4'b0100,
    FCSM_BUF_SETUP = 4'b0101,
    FCSM_BUF_COUNT = 4'b0110,
    FCSM_BUF_DATA = 4'b0111,
    FCSM_BUF_CONF = 4'b1000,
    FCSM_PIN_SETUP = 4'b1001,
    FCSM_LOCK_SETUP = 4'b1010,
    FCSM_LOCK_BUSY = 4'b1011,
    FCSM_SUSP_WAIT = 4'b1100
  } fcsm_state_t;
  // whole module state
  typedef struct packed {
    fcsm_state_t st;
    fcsm_rd_t rd;
    fcsm_ctx_t ctx;
    logic [7:0] status;
    logic [1:0] pin_cfg;
    logic [ADDR_W-1:0] start;
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] left;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] ers_left;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
  } fcsm_state_s_t;
  fcsm_state_s_t s_r; // registered state
  fcsm_state_s_t s_nxt; // next state
  logic [7:0] cmd; // low byte of write data
  logic in_susp; // any suspend context active
  // ==========================================================
  // next-state logic
  always_comb begin
    s_nxt = s_r;
    cmd = bus.wdata[7:0];
    in_susp = (s_r.ctx != FCSM_CTX_NONE);
    s_nxt.rvalid = 1'b0;
    // read port answers one cycle after the strobe
    if (bus.re) begin
      s_nxt.rvalid = 1'b1;
      case (s_r.rd)
        FCSM_RD_STATUS: s_nxt.rdata = {8'h00, s_r.status};
        FCSM_RD_CONFIG: s_nxt.rdata = {14'h0000, s_r.pin_cfg};
        FCSM_RD_QUERY: s_nxt.rdata = 16'h0051;
        default: s_nxt.rdata = bus.addr[DATA_W-1:0];
      endcase
    end
    // timer for internal operations
    if (s_r.tmr != '0) begin
      s_nxt.tmr = s_r.tmr - 1'b1;
    end
    case (s_r.st)
      FCSM_READY: begin
        if (bus.we) begin
          s_nxt.rd = FCSM_RD_ARRAY; // illegal commands fall to array read
          case (cmd)
            CMD_READ_STATUS: s_nxt.rd = FCSM_RD_STATUS;
            CMD_CLEAR_STATUS: begin
              s_nxt.status[5:1] = 5'h00;
            end
            CMD_READ_CONFIG: s_nxt.rd = FCSM_RD_CONFIG;
            CMD_READ_QUERY: s_nxt.rd = FCSM_RD_QUERY;
            CMD_PIN_RECONFIG: begin
              s_nxt.st = FCSM_PIN_SETUP;
              s_nxt.rd = FCSM_RD_STATUS;
            end
            CMD_LOCK_SETUP: begin
              s_nxt.st = FCSM_LOCK_SETUP;
              s_nxt.rd = FCSM_RD_STATUS;
            end
            CMD_ERASE_SETUP: begin
              s_nxt.rd = FCSM_RD_STATUS;
              if (s_r.ctx == FCSM_CTX_NONE) begin
                s_nxt.st = FCSM_ERS_SETUP;
              end else begin
                s_nxt.st = FCSM_ERS_SETUP;
              end
            end
            CMD_WORD_PROG: begin
              s_nxt.rd = FCSM_RD_STATUS;
              if (s_r.ctx != FCSM_CTX_PRG && s_r.ctx != FCSM_CTX_BOTH) begin
                s_nxt.st = FCSM_PRG_SETUP;
              end
            end
            CMD_BUF_WRITE: begin
              s_nxt.rd = FCSM_RD_STATUS;
              if (s_r.status[STS_BIT4] || s_r.status[STS_BIT5]) begin
                s_nxt.st = FCSM_READY;
              end else if (s_r.ctx != FCSM_CTX_PRG && s_r.ctx != FCSM_CTX_BOTH) begin
                s_nxt.st = FCSM_BUF_SETUP;
              end
            end
            CMD_CONFIRM: begin
              // lone D0 is a resume
              s_nxt.rd = FCSM_RD_STATUS;
              if (s_r.ctx == FCSM_CTX_ERS) begin
                s_nxt.ctx = FCSM_CTX_NONE;
                s_nxt.status[STS_ERS_SUSP] = 1'b0;
                s_nxt.status[STS_READY] = 1'b0;
                s_nxt.tmr = s_r.ers_left;
                s_nxt.st = FCSM_ERS_BUSY;
              end else if (in_susp) begin
                s_nxt.ctx = (s_r.ctx == FCSM_CTX_BOTH) ? FCSM_CTX_ERS : FCSM_CTX_NONE;
                s_nxt.status[STS_PRG_SUSP] = 1'b0;
                s_nxt.status[STS_READY] = 1'b0;
                s_nxt.tmr = TMR_W'(PROG_CYC);
                s_nxt.st = FCSM_PRG_BUSY;
              end
            end
            default: s_nxt.rd = FCSM_RD_ARRAY;
          endcase
        end
      end
      FCSM_ERS_SETUP, FCSM_PRG_SETUP: begin
        if (bus.we) begin
          s_nxt.status[STS_READY] = 1'b0;
          if (s_r.st == FCSM_PRG_SETUP) begin
            s_nxt.tmr = TMR_W'(PROG_CYC);
            s_nxt.st = FCSM_PRG_BUSY;
          end else if (cmd == CMD_CONFIRM && !in_susp) begin
            s_nxt.tmr = TMR_W'(ERASE_CYC);
            s_nxt.st = FCSM_ERS_BUSY;
          end else begin
            s_nxt.status = s_r.status | 8'h30;
            s_nxt.st = FCSM_READY;
          end
        end
      end
      FCSM_ERS_BUSY, FCSM_PRG_BUSY, FCSM_LOCK_BUSY: begin
        s_nxt.status[STS_READY] = 1'b0;
        if (bus.we && cmd == CMD_READ_STATUS) begin
          s_nxt.rd = FCSM_RD_STATUS;
        end
        if (bus.we && cmd == CMD_SUSPEND && s_r.st != FCSM_LOCK_BUSY) begin
          s_nxt.ers_left = (s_r.st == FCSM_ERS_BUSY) ? s_r.tmr : s_r.ers_left;
          s_nxt.ctx = (s_r.st == FCSM_ERS_BUSY) ? FCSM_CTX_ERS :
            (s_r.ctx == FCSM_CTX_ERS) ? FCSM_CTX_BOTH : FCSM_CTX_PRG;
          s_nxt.tmr = TMR_W'(SUSP_LAT_CYC);
          s_nxt.st = FCSM_SUSP_WAIT;
        end else if (s_r.tmr == '0) begin
          s_nxt.status[STS_READY] = 1'b1;
          s_nxt.rd = FCSM_RD_STATUS;
          s_nxt.st = FCSM_READY;
        end
      end
      FCSM_SUSP_WAIT: begin
        s_nxt.status[STS_READY] = 1'b0;
        if (s_r.tmr == '0) begin
          s_nxt.status[STS_READY] = 1'b1;
          s_nxt.status[STS_ERS_SUSP] = s_r.ctx[0];
          s_nxt.status[STS_PRG_SUSP] = s_r.ctx[1];
          s_nxt.rd = FCSM_RD_STATUS;
          s_nxt.st = FCSM_READY;
        end
      end
      FCSM_BUF_SETUP: begin
        if (bus.we) begin
          s_nxt.start = bus.addr;
          s_nxt.count = cmd[COUNT_W-1:0];
          s_nxt.left = cmd[COUNT_W-1:0];
          s_nxt.st = FCSM_BUF_DATA;
        end
      end
      FCSM_BUF_DATA: begin
        if (bus.we) begin
          if (bus.addr[ADDR_W-1:16] != s_r.start[ADDR_W-1:16]) begin
            s_nxt.status = s_r.status | 8'h30;
            s_nxt.st = FCSM_READY;
          end else if (s_r.left == '0) begin
            s_nxt.st = FCSM_BUF_CONF;
          end else begin
            s_nxt.left = s_r.left - 1'b1;
          end
        end
      end
      FCSM_BUF_CONF: begin
        if (bus.we) begin
          if (cmd == CMD_CONFIRM) begin
            s_nxt.status[STS_READY] = 1'b0;
            s_nxt.tmr = TMR_W'(PROG_CYC);
            s_nxt.st = FCSM_PRG_BUSY;
          end else begin
            s_nxt.status = s_r.status | 8'h30;
            s_nxt.st = FCSM_READY;
          end
        end
      end
      FCSM_PIN_SETUP: begin
        if (bus.we) begin
          s_nxt.st = FCSM_READY;
          s_nxt.rd = FCSM_RD_STATUS;
          if (bus.wdata <= 16'(PIN_CFG_MAX)) begin
            s_nxt.pin_cfg = cmd[1:0];
          end else begin
            s_nxt.status = s_r.status | 8'h30;
          end
        end
      end
      FCSM_LOCK_SETUP: begin
        if (bus.we) begin
          s_nxt.status[STS_READY] = 1'b0;
          s_nxt.tmr = TMR_W'(LOCK_CYC);
          s_nxt.st = FCSM_LOCK_BUSY;
        end
      end
      default: s_nxt.st = FCSM_READY;
    endcase
  end
  // ==========================================================
  // state register
  always_ff @(posedge bus.clk_in) begin
    if (!bus.rst_n_in) begin
      s_r <= '{st: FCSM_READY, rd: FCSM_RD_ARRAY, ctx: FCSM_CTX_NONE,
        status: STATUS_RST, pin_cfg: PIN_CFG_RST, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end
  // ==========================================================
  // outputs
  assign bus.rdata = s_r.rdata;
  assign bus.rvalid = s_r.rvalid;
  assign bus.status_output_pin = s_r.status[STS_READY];
  assign pin_cfg_out = s_r.pin_cfg;
  assign buf_start_out = s_r.start;
  assign buf_count_out = s_r.count;
  assign suspend_ctx_out = s_r.ctx;
endmodule
`default_nettype wire

// file: rtl/fcsm_pkg.sv
// package of command codes, status bits, timing, read selector and suspend context for the flash command machine
`default_nettype none
package fcsm_pkg;
  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_CONFIG = 8'h90;
  localparam logic [7:0] CMD_PIN_RECONFIG = 8'hB8;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_PROT_SETUP = 8'hC0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_BUF_WRITE = 8'hE8;
  localparam logic [7:0] CMD_WORD_PROG = 8'h40;
  localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
  localparam logic [7:0] PIN_CFG_MAX = 8'h03;
  // ==========================================================
  // status bit positions
  localparam int STS_READY = 7;
  localparam int STS_ERS_SUSP = 6;
  localparam int STS_BIT5 = 5;
  localparam int STS_BIT4 = 4;
  localparam int STS_PRG_SUSP = 2;
  localparam logic [7:0] STATUS_RST = 8'h80;
  localparam logic [1:0] PIN_CFG_RST = 2'h0;
  // ==========================================================
  // host register offsets
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_WRITE = 8'h04;
  localparam logic [7:0] OFS_READ = 8'h08;
  localparam logic [7:0] OFS_IRQ = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  // ==========================================================
  // widths and timing
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int COUNT_W = 5;
  localparam int CLK_MHZ = 40;
  localparam int SUSP_LAT_US = 25;
  localparam int SUSP_LAT_CYC = SUSP_LAT_US * CLK_MHZ;
  localparam int ERASE_CYC = 4000;
  localparam int PROG_CYC = 400;
  localparam int LOCK_CYC = 40;
  localparam int TMR_W = 13;
  // ==========================================================
  // read output selector
  typedef enum logic [1:0] {
    FCSM_RD_ARRAY = 2'b00,
    FCSM_RD_STATUS = 2'b01,
    FCSM_RD_CONFIG = 2'b10,
    FCSM_RD_QUERY = 2'b11
  } fcsm_rd_t;
  // suspend context
  typedef enum logic [1:0] {
    FCSM_CTX_NONE = 2'b00,
    FCSM_CTX_ERS = 2'b01,
    FCSM_CTX_PRG = 2'b10,
    FCSM_CTX_BOTH = 2'b11
  } fcsm_ctx_t;
endpackage
`default_nettype wire

// file: rtl/fcsm_if.sv
// interface joining the host end and the flash command machine end
`default_nettype none
interface fcsm_if (
  input wire logic clk_in,
  input wire logic rst_n_in
);
  import fcsm_pkg::*;
  logic we; // one-cycle write strobe
  logic re; // one-cycle read strobe
  logic [ADDR_W-1:0] addr; // cycle address
  logic [DATA_W-1:0] wdata; // write data
  logic [DATA_W-1:0] rdata; // read data, valid the cycle after re
  logic rvalid; // read answer strobe
  logic status_output_pin; // ready/busy style pin
  modport device (input clk_in, rst_n_in, we, re, addr, wdata,
    output rdata, rvalid, status_output_pin);
  modport host (input clk_in, rst_n_in, rdata, rvalid, status_output_pin,
    output we, re, addr, wdata);
endinterface
`default_nettype wire

// file: rtl/fcsm_host.sv
// host end: apb registers issue command cycles to the flash machine
`default_nettype none
module fcsm_host
  import fcsm_pkg::*;
(
  fcsm_if.host bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq_out
);
  // ==========================================================
  // registered host state
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wd; // write data held for the strobe cycle
    logic [DATA_W-1:0] rdata;
    logic [1:0] irq;
    logic [1:0] mask;
    logic pin_d;
    logic we;
    logic re;
    logic busy;
  } fcsm_host_s_t;
  fcsm_host_s_t s_r; // registered state
  fcsm_host_s_t s_nxt; // next state
  logic acc; // apb access phase
  // ==========================================================
  // next-state logic
  always_comb begin
    s_nxt = s_r;
    acc = psel && penable;
    s_nxt.we = 1'b0;
    s_nxt.re = 1'b0;
    s_nxt.pin_d = bus.status_output_pin;
    // irq 0 read done, irq 1 ready rising; set wins over clear
    if (acc && pwrite && paddr == OFS_IRQ) begin
      s_nxt.irq = s_r.irq & ~pwdata[1:0];
    end
    if (bus.rvalid) begin
      s_nxt.rdata = bus.rdata;
      s_nxt.busy = 1'b0;
      s_nxt.irq[0] = 1'b1;
    end
    if (bus.status_output_pin && !s_r.pin_d) begin
      s_nxt.irq[1] = 1'b1;
    end
    if (acc && pwrite) begin
      case (paddr)
        OFS_ADDR: s_nxt.addr = pwdata[ADDR_W-1:0];
        OFS_WRITE: begin
          s_nxt.we = 1'b1;
          s_nxt.wd = pwdata[DATA_W-1:0];
        end
        OFS_READ: begin
          s_nxt.re = 1'b1;
          s_nxt.busy = 1'b1;
        end
        OFS_MASK: s_nxt.mask = pwdata[1:0];
        default: s_nxt.mask = s_r.mask;
      endcase
    end
  end
  always_ff @(posedge bus.clk_in) begin
    if (!bus.rst_n_in) begin
      // edge detector starts at the pin's idle high level: no false ready edge
      s_r <= '{pin_d: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end
  assign bus.we = s_r.we;
  assign bus.re = s_r.re;
  assign bus.addr = s_r.addr;
  assign bus.wdata = s_r.wd;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign irq_out = |(s_r.irq & s_r.mask);
  // apb read mux
  always_comb begin
    case (paddr)
      OFS_ADDR: prdata = {8'h00, s_r.addr};
      OFS_READ: prdata = {15'h0000, s_r.busy, s_r.rdata};
      OFS_IRQ: prdata = {30'h0, s_r.irq};
      OFS_MASK: prdata = {30'h0, s_r.mask};
      default: prdata = 32'h00000000;
    endcase
  end
endmodule
`default_nettype wire

// file: bench/fcsm_link_chk.sv
// checker on the link between the host end and the flash machine end
`default_nettype none
module fcsm_link_chk
  import fcsm_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic we,
  input wire logic re,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic rvalid,
  input wire logic status_output_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // command history
  logic [7:0] cmd; // command byte of this cycle
  logic [7:0] last_r; // last command byte
  logic bad_r; // bad reconfig value, error read pending
  logic clr_r; // clear status seen
  logic susp_r; // suspend issued while busy
  logic [10:0] lat_r; // cycles since suspend request
  assign cmd = wdata[7:0];
  // track commands; a status read keeps the pending flags
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      last_r <= 8'hFF;
      bad_r <= 1'b0;
      clr_r <= 1'b0;
      susp_r <= 1'b0;
    end else if (we) begin
      last_r <= cmd;
      bad_r <= (last_r == CMD_PIN_RECONFIG && wdata > 16'h0003) ||
        (bad_r && cmd == CMD_READ_STATUS);
      clr_r <= cmd == CMD_CLEAR_STATUS || (clr_r && cmd == CMD_READ_STATUS);
      if (cmd == CMD_SUSPEND && !status_output_pin) begin
        susp_r <= 1'b1;
      end else if (cmd == CMD_CONFIRM && last_r == CMD_READ_STATUS) begin
        susp_r <= 1'b0;
      end
    end
  end
  logic s_go; // suspend request while busy
  assign s_go = we && cmd == CMD_SUSPEND && !status_output_pin;
  // latency counter, clears to zero when ready returns
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      lat_r <= 11'h000;
    end else if (s_go) begin
      lat_r <= 11'h001;
    end else if (lat_r != 11'h000) begin
      lat_r <= status_output_pin ? 11'h000 : lat_r + 11'h001;
    end
  end
  sequence s_erase_go;
    we && cmd == CMD_CONFIRM && last_r == CMD_ERASE_SETUP && status_output_pin && !susp_r;
  endsequence
  sequence s_resume;
    we && cmd == CMD_CONFIRM && last_r == CMD_READ_STATUS && susp_r;
  endsequence
  // ==========================================================
  // assertions
  chk_read_answer: assert property (re |=> rvalid)
    else $error("no read answer after read strobe");
  chk_answer_cause: assert property (rvalid |-> $past(re))
    else $error("read answer without read strobe");
  chk_pin_reset: assert property ($rose(rst_n_in) |-> status_output_pin)
    else $error("ready pin low after reset");
  chk_bad_reconfig: assert property (rvalid && bad_r |-> rdata[5:4] == 2'b11)
    else $error("bad reconfig value not flagged");
  chk_clear_works: assert property (rvalid && clr_r && last_r == CMD_READ_STATUS |->
    rdata[5:4] == 2'b00)
    else $error("error bits survive clear status");
  chk_ready_mirror: assert property (rvalid && last_r == CMD_READ_STATUS &&
    $stable(status_output_pin) |-> rdata[7] == status_output_pin)
    else $error("ready bit and pin disagree");
  chk_erase_busy: assert property (s_erase_go |-> ##[1:3] !status_output_pin)
    else $error("erase confirm did not go busy");
  chk_susp_hold: assert property (lat_r != 11'h000 && lat_r < 11'd995 |->
    !status_output_pin)
    else $error("suspended before latency");
  chk_susp_enter: assert property (lat_r != 11'h000 |-> lat_r <= 11'd1005)
    else $error("suspend not entered after latency");
  chk_resume_go: assert property (s_resume |-> ##[1:3] !status_output_pin)
    else $error("resume did not restart work");
  chk_no_resume: assert property (we && cmd == CMD_CONFIRM && last_r == CMD_ERASE_SETUP &&
    susp_r |=> status_output_pin [*4])
    else $error("erase confirm resumed from suspend");
endmodule
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench: apb stimulus into host end, link watched at device end
`default_nettype none
`define CHECK(n, e, a) cmp(n, 32'(e), 32'(a))
module testbench
  import fcsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0; // 40 MHz clock
  logic rst_n_in = 1'b0; // sync reset, active low
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, irq;
  logic [1:0] pin_cfg, ctx;
  logic [ADDR_W-1:0] start, st;
  logic [COUNT_W-1:0] count;
  logic [15:0] pc; // random valid pin setting
  logic [7:0] exp_q[$]; // expected link read data
  int error_cnt = 0;
  int n_compared = 0;
  always #12.5 clk_in = ~clk_in;
  fcsm_if lnk (.clk_in(clk_in), .rst_n_in(rst_n_in));
  fcsm_device fcsm_device_inst (.bus(lnk), .pin_cfg_out(pin_cfg), .buf_start_out(start),
    .buf_count_out(count), .suspend_ctx_out(ctx));
  fcsm_host fcsm_host_inst (.bus(lnk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_out(irq));
  fcsm_link_chk fcsm_link_chk_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .we(lnk.we),
    .re(lnk.re), .wdata(lnk.wdata), .rdata(lnk.rdata), .rvalid(lnk.rvalid),
    .status_output_pin(lnk.status_output_pin));
  // compare and count
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] a);
    n_compared++;
    if (a !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, a);
    end
  endtask
  // one apb transfer; read data lands in q
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    q = prdata;
    `CHECK("slave error", 1'b0, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  // one link write cycle: address, then data
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    apb(1'b1, 8'h00, 32'(a));
    apb(1'b1, 8'h04, {16'h0, d});
  endtask
  task automatic cm(input logic [ADDR_W-1:0] a, input logic [7:0] c);
    wr(a, {8'h00, c});
  endtask
  // link read; the watcher compares the answer
  task automatic rd(input logic [7:0] e);
    exp_q.push_back(e);
    apb(1'b1, 8'h08, 32'h0);
  endtask
  // wait for the ready pin, bounded by the watchdog
  task automatic wait_pin(input logic v);
    repeat (4) @(posedge clk_in);
    while (lnk.status_output_pin !== v) @(posedge clk_in);
  endtask
  task automatic wrap_up();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watcher: each link answer against the oldest note
  always @(posedge clk_in) begin
    if (rst_n_in && lnk.rvalid === 1'b1) begin
      if (exp_q.size() == 0) `CHECK("unexpected read", 0, 1);
      else `CHECK("link read", exp_q.pop_front(), lnk.rdata[7:0]);
    end
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    wrap_up();
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(76));
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    apb(1'b0, 8'h0C, 32'h0);
    `CHECK("irq after reset", 32'h0, q);
    cm(24'h0, CMD_READ_STATUS);
    rd(8'h80);
    pc = 16'($urandom_range(3));
    cm(24'h0, CMD_PIN_RECONFIG);
    wr(24'h0, pc);
    rd(8'h80);
    `CHECK("pin config", pc, pin_cfg);
    cm(24'h0, CMD_PIN_RECONFIG);
    wr(24'h0, 16'(4 + $urandom_range(250)));
    rd(8'hB0);
    st = {8'h12, 16'($urandom_range(16'hFF00))};
    cm(st, CMD_BUF_WRITE);
    wr(st + 24'h10, 16'h0003);
    `CHECK("start kept", 1'b0, start == st + 24'h10);
    cm(24'h0, CMD_CLEAR_STATUS);
    cm(24'h0, CMD_READ_STATUS);
    rd(8'h80);
    cm(st, CMD_BUF_WRITE);
    wr(st, 16'hFFE3);
    `CHECK("buffer start", st, start);
    `CHECK("word count", 5'h03, count);
    for (int i = 0; i < 4; i++) wr(st + 24'(i), {8'($urandom), 8'h5A});
    cm(st, CMD_CONFIRM);
    wait_pin(1'b1);
    rd(8'h80);
    // single word program, then a block change aborting a buffered write
    cm(24'h0, CMD_WORD_PROG);
    wr(24'h0, {8'($urandom), 8'h5A});
    wait_pin(1'b1);
    rd(8'h80);
    cm(st, CMD_BUF_WRITE);
    wr(st, 16'h0001);
    wr(st + 24'h010000, 16'h0000);
    rd(8'hB0);
    cm(24'h0, CMD_CLEAR_STATUS);
    // erase, suspend and work inside the suspend
    cm(24'h020000, CMD_ERASE_SETUP);
    cm(24'h020000, CMD_CONFIRM);
    rd(8'h00);
    cm(24'h0, CMD_SUSPEND);
    rd(8'h00);
    wait_pin(1'b1);
    `CHECK("suspend context", FCSM_CTX_ERS, ctx);
    rd(8'hC0);
    cm(24'h0, CMD_PIN_RECONFIG);
    wr(24'h0, 16'h0009);
    rd(8'hF0);
    cm(24'h0, CMD_CLEAR_STATUS);
    cm(24'h0, CMD_READ_STATUS);
    rd(8'hC0);
    cm(24'h0, CMD_PIN_RECONFIG);
    wr(24'h0, 16'h0001);
    rd(8'hC0);
    `CHECK("pin config", 2'h1, pin_cfg);
    cm(24'h0, CMD_READ_CONFIG);
    rd(8'h01);
    cm(24'h030000, CMD_LOCK_SETUP);
    cm(24'h030000, CMD_LOCK_BLOCK);
    repeat (LOCK_CYC + 20) @(posedge clk_in);
    rd(8'hC0);
    cm(24'h0, CMD_ERASE_SETUP);
    cm(24'h0, CMD_CONFIRM);
    `CHECK("no resume", FCSM_CTX_ERS, ctx);
    cm(24'h0, CMD_CLEAR_STATUS);
    cm(24'h0, CMD_READ_STATUS);
    `CHECK("context kept", FCSM_CTX_ERS, ctx);
    cm(24'h0, CMD_CONFIRM);
    `CHECK("resumed", FCSM_CTX_NONE, ctx);
    wait_pin(1'b1);
    rd(8'h80);
    // interrupt: ready event, mask, clear; unmapped read
    apb(1'b0, 8'h0C, 32'h0);
    `CHECK("ready event", 1'b1, q[1]);
    `CHECK("read event", 1'b1, q[0]);
    `CHECK("masked irq", 1'b0, irq);
    apb(1'b1, 8'h10, 32'h2);
    `CHECK("irq raised", 1'b1, irq);
    apb(1'b1, 8'h0C, 32'h3);
    `CHECK("irq cleared", 1'b0, irq);
    apb(1'b0, 8'h40, 32'h0);
    `CHECK("unmapped read", 32'h0, q);
    apb(1'b1, 8'h00, {8'h00, st});
    apb(1'b0, 8'h00, 32'h0);
    `CHECK("address readback", {8'h00, st}, q);
    apb(1'b0, 8'h08, 32'h0);
    `CHECK("last read result", 32'h80, q);
    `CHECK("reads left", 0, exp_q.size());
    wrap_up();
  end
endmodule
`default_nettype wire
